// >>> core_model.sv
`timescale 1ns/100ps

module core_model
    import irq_dist_pkg::*;
(
    input wire logic sys_clk,
    input wire regData_t rdata,
    output regReq_s busReq
);
    // ==========================================
    // one-cycle strobes, fields held until taken
    initial busReq = '0;

    task automatic wr(input regAddr_t a, input regData_t d, input logic ns);
        @(posedge sys_clk);
        busReq <= '{a, d, 1'b1, 1'b0, ns};
        @(posedge sys_clk);
        busReq.wr <= 1'b0;
    endtask

    task automatic rd(input regAddr_t a, input logic ns, output regData_t d);
        @(posedge sys_clk);
        busReq <= '{a, 32'h0000_0000, 1'b0, 1'b1, ns};
        @(posedge sys_clk);
        busReq.rd <= 1'b0;
        #1;
        d = rdata;
    endtask
endmodule

// >>> irq_dist_params.svh
// Functional notes
// - control register banked by access security
// - secure view: bit1 nonsecure, bit0 secure
// - nonsecure view: bit0 nonsecure enable only
// - secure enable low freezes secure state
// - secure enable high lets secure state track
// - nonsecure enable freezes or releases nonsecure state
// - type bits 15:11 read lockable count 31
// - lock input blocks lockable interrupt configuration writes
// - type bit 10 always reads one
// - type bits 7:5 give cores minus one
// - type bits 4:0 give lines/32
// - identifiers 0 to 31 stay private
// - lock blocks secure enable, not nonsecure
// - up to 224 shared lines from 32
`ifndef IRQ_DIST_PARAMS_SVH
`define IRQ_DIST_PARAMS_SVH

// ============================================================
// register offsets
`define CTRL_OFFSET 12'h000
`define TYPE_OFFSET 12'h004
`define SECURITY_BASE 12'h084

// ============================================================
// field positions
`define CTRL_SEC_EN_BIT 0
`define CTRL_NS_EN_BIT 1
`define CTRL_NSVIEW_EN_BIT 0

// ============================================================
// field values and reset values
`define TYPE_LOCK_COUNT 5'h1F
`define TYPE_TWO_DOMAIN 1'b1
`define LOCK_LINES 31
`define PRIVATE_IDS 32
`define MAX_SPI_LINES 224
`define MAX_CPUS 4
`define ENABLE_RESET 1'b0
`define SECURITY_RESET 32'h0000_0000
`define RDATA_RESET 32'h0000_0000

`endif

// >>> irq_dist_pkg.sv
package irq_dist_pkg;
    typedef logic [11:0] regAddr_t;
    typedef logic [31:0] regData_t;

    // one register access from a core
    typedef struct packed {
        regAddr_t addr;
        regData_t wdata;
        logic wr;
        logic rd;
        logic nonsecure;
    } regReq_s;

    // the two domain enables
    typedef struct packed {
        logic nsEn;
        logic secEn;
    } domainEn_s;
endpackage

// >>> irq_distributor_ctrl_type_regs.sv
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "irq_dist_params.svh"

module irq_distributor_ctrl_type_regs
    import irq_dist_pkg::*;
#(
    parameter int SPI_LINES = `MAX_SPI_LINES,
    parameter int NUM_CPUS = 1
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire regReq_s busReq,
    output regData_t rdata,
    input wire logic configLockInput,
    input wire logic [SPI_LINES-1:0] spiLines,
    output domainEn_s domainEnable,
    output logic lockActive,
    output logic [SPI_LINES-1:0] lineState
);

    localparam int NUM_WORDS = SPI_LINES / 32;

    // ============================================================
    // elaboration checks
    if (SPI_LINES < 32 || SPI_LINES > `MAX_SPI_LINES
        || SPI_LINES % 32 != 0)
    begin
        $error("SPI_LINES must be 32..224 in steps of 32");
    end
    if (NUM_CPUS < 1 || NUM_CPUS > `MAX_CPUS)
    begin
        $error("NUM_CPUS must be 1..4");
    end

    // ============================================================
    // type register value
    // lines field counts the shared lines only, in groups of 32
    localparam logic [4:0] LINE_FIELD = 5'(NUM_WORDS);
    localparam logic [2:0] CPU_FIELD = 3'(NUM_CPUS - 1);
    localparam regData_t TYPE_VALUE = {16'h0000,
        `TYPE_LOCK_COUNT, `TYPE_TWO_DOMAIN, 2'b00,
        CPU_FIELD, LINE_FIELD};

    // ============================================================
    // address decode
    function automatic logic secHit(input regAddr_t a);
        regAddr_t off;
        off = a - `SECURITY_BASE;
        secHit = (a >= `SECURITY_BASE) && (off[1:0] == 2'b00)
            && (off[11:2] < 10'(NUM_WORDS));
    endfunction

    function automatic int secIdx(input regAddr_t a);
        regAddr_t off;
        off = a - `SECURITY_BASE;
        secIdx = int'(off[11:2]);
    endfunction

    // ============================================================
    // lock input synchroniser
    logic [2:0] lockSync_r;
    logic [2:0] lockSync_nxt;
    logic lockActive_r;
    logic lockActive_nxt;

    always_comb
    begin
        lockSync_nxt = {lockSync_r[1:0], configLockInput};
        lockActive_nxt = lockActive_r;
        // change counts once second and third stage agree
        if (lockSync_r[1] == lockSync_r[2])
        begin
            lockActive_nxt = lockSync_r[2];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            lockSync_r <= 3'h0;
            lockActive_r <= 1'b0;
        end
        else
        begin
            lockSync_r <= lockSync_nxt;
            lockActive_r <= lockActive_nxt;
        end
    end

    // ============================================================
    // register file
    domainEn_s en_r;
    domainEn_s en_nxt;
    regData_t secWord_r [NUM_WORDS];
    regData_t secWord_nxt [NUM_WORDS];
    regData_t rdata_r;
    regData_t rdata_nxt;

    always_comb
    begin
        en_nxt = en_r;
        secWord_nxt = secWord_r;
        rdata_nxt = `RDATA_RESET;
        if (busReq.wr && busReq.addr == `CTRL_OFFSET)
        begin
            if (busReq.nonsecure)
            begin
                en_nxt.nsEn = busReq.wdata[`CTRL_NSVIEW_EN_BIT];
            end
            else
            begin
                en_nxt.nsEn = busReq.wdata[`CTRL_NS_EN_BIT];
                if (!lockActive_r)
                begin
                    en_nxt.secEn = busReq.wdata[`CTRL_SEC_EN_BIT];
                end
            end
        end
        // security words are secure only
        if (busReq.wr && !busReq.nonsecure && secHit(busReq.addr))
        begin
            for (int b = 0; b < 32; b++)
            begin
                // lockable ids 32..62 are the first shared lines
                if (!(lockActive_r && secIdx(busReq.addr) * 32 + b
                    < `LOCK_LINES))
                begin
                    secWord_nxt[secIdx(busReq.addr)][b] =
                        busReq.wdata[b];
                end
            end
        end
        if (busReq.rd)
        begin
            if (busReq.addr == `CTRL_OFFSET)
            begin
                if (busReq.nonsecure)
                begin
                    rdata_nxt[`CTRL_NSVIEW_EN_BIT] = en_r.nsEn;
                end
                else
                begin
                    rdata_nxt[`CTRL_NS_EN_BIT] = en_r.nsEn;
                    rdata_nxt[`CTRL_SEC_EN_BIT] = en_r.secEn;
                end
            end
            else if (busReq.addr == `TYPE_OFFSET)
            begin
                rdata_nxt = TYPE_VALUE;
            end
            else if (!busReq.nonsecure && secHit(busReq.addr))
            begin
                rdata_nxt = secWord_r[secIdx(busReq.addr)];
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            en_r <= '{nsEn: `ENABLE_RESET, secEn: `ENABLE_RESET};
            for (int w = 0; w < NUM_WORDS; w++)
            begin
                secWord_r[w] <= `SECURITY_RESET;
            end
            rdata_r <= `RDATA_RESET;
        end
        else
        begin
            en_r <= en_nxt;
            secWord_r <= secWord_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ============================================================
    // shared line state tracking
    logic [SPI_LINES-1:0] secMask;
    logic [SPI_LINES-1:0] lineState_r;
    logic [SPI_LINES-1:0] lineState_nxt;

    always_comb
    begin
        secMask = '0;
        lineState_nxt = lineState_r;
        for (int i = 0; i < SPI_LINES; i++)
        begin
            secMask[i] = secWord_r[i / 32][i % 32];
            // each line follows its input only while its domain runs
            if (secMask[i] ? en_r.secEn : en_r.nsEn)
            begin
                lineState_nxt[i] = spiLines[i];
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            lineState_r <= '0;
        end
        else
        begin
            lineState_r <= lineState_nxt;
        end
    end

    assign rdata = rdata_r;
    assign domainEnable = en_r;
    assign lockActive = lockActive_r;
    assign lineState = lineState_r;

    // ============================================================
    // assertions
    // tracking checks skip the first edge after reset
    a_sec_freeze: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        $past(rst_n) && !$past(en_r.secEn) |->
        ((lineState_r ^ $past(lineState_r)) & $past(secMask)) == '0)
        else $error("secure state moved while disabled");

    a_sec_track: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        $past(rst_n) && $past(en_r.secEn) |->
        (lineState_r & $past(secMask))
        == ($past(spiLines) & $past(secMask)))
        else $error("secure state did not follow lines");

    a_ns_freeze: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        $past(rst_n) && !$past(en_r.nsEn) |->
        ((lineState_r ^ $past(lineState_r)) & ~$past(secMask)) == '0)
        else $error("nonsecure state moved while disabled");

    a_ns_track: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        $past(rst_n) && $past(en_r.nsEn) |->
        (lineState_r & ~$past(secMask))
        == ($past(spiLines) & ~$past(secMask)))
        else $error("nonsecure state did not follow lines");

    a_type_read: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        busReq.rd && busReq.addr == `TYPE_OFFSET |=>
        rdata == TYPE_VALUE && rdata[10] && rdata[15:11] == 5'h1F)
        else $error("type register read wrong");

    a_type_fields: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        busReq.rd && busReq.addr == `TYPE_OFFSET |=>
        rdata[31:16] == 16'h0000 && rdata[9:8] == 2'b00
        && rdata[7:5] == 3'(NUM_CPUS - 1) && rdata[4:0] == 5'(SPI_LINES / 32))
        else $error("type register fields wrong");

    a_lock_secen: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        lockActive_r && busReq.wr && !busReq.nonsecure
        && busReq.addr == `CTRL_OFFSET |=> $stable(en_r.secEn)
        && en_r.nsEn == $past(busReq.wdata[1]))
        else $error("secure enable written under lock");

    a_sec_view: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        !lockActive_r && busReq.wr && !busReq.nonsecure
        && busReq.addr == `CTRL_OFFSET
        |=> en_r.secEn == $past(busReq.wdata[0])
        && en_r.nsEn == $past(busReq.wdata[1]))
        else $error("secure view write wrong");

    a_ns_view: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        busReq.wr && busReq.nonsecure && busReq.addr == `CTRL_OFFSET
        |=> en_r.nsEn == $past(busReq.wdata[0])
        && $stable(en_r.secEn))
        else $error("nonsecure view write wrong");

    a_ns_read: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        busReq.rd && busReq.nonsecure && busReq.addr == `CTRL_OFFSET
        |=> rdata == {31'h0000_0000, $past(en_r.nsEn)})
        else $error("nonsecure view read wrong");

    a_sec_read: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        busReq.rd && !busReq.nonsecure && busReq.addr == `CTRL_OFFSET
        |=> rdata[1:0] == {$past(en_r.nsEn), $past(en_r.secEn)})
        else $error("secure view read wrong");

    a_lock_cfg: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        lockActive_r
        |=> secWord_r[0][30:0] == $past(secWord_r[0][30:0]))
        else $error("lockable configuration changed under lock");

    a_ctrl_rsv: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        busReq.rd && busReq.addr == `CTRL_OFFSET |=>
        rdata[31:2] == 30'h0 && (!$past(busReq.nonsecure)
        || rdata[1] == 1'b0))
        else $error("reserved control bits not zero");

    a_en_hold: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        !(busReq.wr && busReq.addr == `CTRL_OFFSET) |=> $stable(en_r))
        else $error("enables changed without a write");

    a_reset_en: assert property (@(posedge sys_clk)
        !rst_n |=> !en_r.nsEn && !en_r.secEn)
        else $error("enables not cleared by reset");

endmodule

// >>> irq_distributor_ctrl_type_regs_tb.sv
`timescale 1ns/100ps

module irq_distributor_ctrl_type_regs_tb
    import irq_dist_pkg::*;
;
    localparam regAddr_t CTRL = 12'h000;
    localparam regAddr_t TYPE = 12'h004;
    localparam regAddr_t SECW = 12'h084;
    localparam logic [63:0] ONES = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [63:0] NSONLY = 64'hFFFF_FFFF_FFFF_FFFE;
    logic sys_clk;
    logic rst_n;
    regReq_s busReq;
    regData_t rdata;
    logic configLockInput;
    logic [63:0] spiLines;
    domainEn_s domainEnable;
    logic lockActive;
    logic [63:0] lineState;
    int n_errors = 0;
    int checked = 0;

    irq_distributor_ctrl_type_regs #(.SPI_LINES(64), .NUM_CPUS(4))
        irq_distributor_ctrl_type_regs_i (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .busReq(busReq),
        .rdata(rdata),
        .configLockInput(configLockInput),
        .spiLines(spiLines),
        .domainEnable(domainEnable),
        .lockActive(lockActive),
        .lineState(lineState)
    );

    core_model core_model_i (
        .sys_clk(sys_clk),
        .rdata(rdata),
        .busReq(busReq)
    );

    // ==========================================
    // clock and watchdog
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        #20000;
        n_errors++;
        wrap_up();
    end

    // ==========================================
    // helpers
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input regAddr_t a, input logic ns, input regData_t e);
        regData_t d;
        core_model_i.rd(a, ns, d);
        chk(64'(d), 64'(e));
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wrap_up();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========================================
    // tests
    initial
    begin
        rst_n = 1'b0;
        configLockInput = 1'b0;
        spiLines = '0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(1);
        chk(64'(domainEnable), 64'h0);
        rchk(CTRL, 1'b0, 32'h0000_0000);
        rchk(TYPE, 1'b0, 32'h0000_FC62);
        core_model_i.wr(TYPE, 32'hFFFF_FFFF, 1'b0);
        rchk(TYPE, 1'b0, 32'h0000_FC62);
        rchk(12'h008, 1'b0, 32'h0000_0000);
        @(posedge sys_clk);
        spiLines <= ONES;
        tick(3);
        chk(lineState, 64'h0);
        // line 32 becomes secure
        core_model_i.wr(SECW, 32'h0000_0001, 1'b0);
        rchk(SECW, 1'b1, 32'h0000_0000);
        rchk(SECW, 1'b0, 32'h0000_0001);
        core_model_i.wr(CTRL, 32'hFFFF_FFFE, 1'b0);
        rchk(CTRL, 1'b0, 32'h0000_0002);
        rchk(CTRL, 1'b1, 32'h0000_0001);
        tick(3);
        chk(lineState, NSONLY);
        core_model_i.wr(CTRL, 32'h0000_0003, 1'b0);
        tick(3);
        chk(lineState, ONES);
        core_model_i.wr(CTRL, 32'hFFFF_FFFE, 1'b1);
        rchk(CTRL, 1'b0, 32'h0000_0001);
        @(posedge sys_clk);
        spiLines <= '0;
        tick(3);
        chk(lineState, NSONLY);
        @(posedge sys_clk);
        configLockInput <= 1'b1;
        tick(8);
        chk(64'(lockActive), 64'h1);
        core_model_i.wr(CTRL, 32'h0000_0002, 1'b0);
        rchk(CTRL, 1'b0, 32'h0000_0003);
        core_model_i.wr(SECW, 32'h8000_0000, 1'b0);
        rchk(SECW, 1'b0, 32'h8000_0001);
        // mid-run reset with both domains running
        @(posedge sys_clk);
        spiLines <= ONES;
        tick(2);
        chk(lineState, ONES);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(1);
        chk(64'(domainEnable), 64'h0);
        chk(lineState, 64'h0);
        wrap_up();
    end
endmodule
